// ==== hdl/lpr_route.sv ====
// Top: I/O cycle steering plus legacy and PCI interrupt routing.
// Assumes: inputs synchronous to clk; serial IRQ frames already decoded per slot.
// Functional notes
// - Unclaimed I/O cycles outside the LPC windows go subtractively to PCI
// - Only fixed legacy windows go to LPC
// - Lines 0,1,2,8,9,13 stay internal
// - Lines 14,15 freed outside legacy IDE
// - APIC 16 carries PCI line A
// - APIC 17 carries PCI line B
// - APIC 18 carries PCI line C
// - APIC 19 carries PCI line D
// - Single-function port interrupt follows port map
// - Multifunction pins swizzled across lines per port
`timescale 1ns/1ps
`default_nettype none
module lpr_route
  import lpr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire lpr_io_req_s   io_req,
  input  wire logic          io_claimed,
  input  wire logic          legacy_ide_mode,
  input  wire logic [15:0]   serirq_slots,
  input  wire logic [1:0]    ide_irq,
  input  wire logic [15:0]   internal_irq,
  input  wire logic [3:0]    onboard_int,
  input  wire lpr_port_int_s ext_port_int [LPR_NUM_EXT_PORT],
  input  wire logic [3:0]    pci_int_line_efgh,
  output lpr_tgt_e           io_tgt_q,
  output logic [15:0]        legacy_irq_q,
  output logic [7:0]         apic_hi_irq_q
);

  // ----------------------------------------
  // I/O decode
  // ----------------------------------------
  logic [LPR_NUM_WIN-1:0] win_hit;

  genvar w;
  generate
    for (w = 0; w < LPR_NUM_WIN; w++) begin : g_win
      if (w < LPR_USED_WIN) begin : g_used
        assign win_hit[w] = (io_req.addr >= LPR_WIN_LO[w]) && (io_req.addr <= LPR_WIN_HI[w]);
      end else begin : g_spare
        assign win_hit[w] = 1'b0;
      end
    end
  endgenerate

  // Positive claim by another agent takes the cycle away from both buses
  always_ff @(posedge clk) begin
    if (rst) begin
      io_tgt_q <= LPR_TGT_NONE;
    end else if (!io_req.valid || io_claimed) begin
      io_tgt_q <= LPR_TGT_NONE;
    end else if (|win_hit) begin
      io_tgt_q <= LPR_TGT_LPC;
    end else begin
      io_tgt_q <= LPR_TGT_PCI;
    end
  end

  // ----------------------------------------
  // Legacy lines
  // ----------------------------------------
  logic [15:0] legacy_d;

  always_comb begin
    legacy_d = (serirq_slots & ~LPR_IRQ_INTERNAL) | (internal_irq & LPR_IRQ_INTERNAL);
    if (legacy_ide_mode) begin
      legacy_d[15:14] = ide_irq;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      legacy_irq_q <= LPR_RST_IRQ;
    end else begin
      legacy_irq_q <= legacy_d;
    end
  end

  // ----------------------------------------
  // PCI lines onto APIC 16..23
  // ----------------------------------------
  // Level-sensitive wired-OR; sharing is the point of these lines
  logic [3:0] pci_abcd;

  always_comb begin
    pci_abcd = onboard_int;
    for (int p = 0; p < LPR_NUM_EXT_PORT; p++) begin
      for (int i = 0; i < 4; i++) begin
        pci_abcd[2'(LPR_PORT_SWZ[p] + 2'(i))] |= ext_port_int[p].intx[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      apic_hi_irq_q <= LPR_RST_APIC;
    end else begin
      apic_hi_irq_q <= {pci_int_line_efgh, pci_abcd};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_io_to_lpc: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h0064) |=> io_tgt_q == LPR_TGT_LPC)
    else $error("port 64h not sent to LPC");
  chk_io_window_edge: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h0c00) |=> io_tgt_q == LPR_TGT_PCI)
    else $error("address above window not subtractive");
  chk_io_claimed: assert property (io_claimed |=> io_tgt_q == LPR_TGT_NONE)
    else $error("claimed cycle forwarded");
  chk_io_port61: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h0061) |=> io_tgt_q == LPR_TGT_PCI)
    else $error("port 61h sent to LPC");
  chk_internal_lines: assert property (1'b1 |=> (legacy_irq_q & LPR_IRQ_INTERNAL) == ($past(internal_irq) & LPR_IRQ_INTERNAL))
    else $error("internal line taken by serial slot");
  chk_ide_lines: assert property (legacy_ide_mode |=> legacy_irq_q[15:14] == $past(ide_irq))
    else $error("IDE lines not routed");
  chk_free_lines: assert property (!legacy_ide_mode |=> legacy_irq_q[15:14] == $past(serirq_slots[15:14]))
    else $error("lines 14/15 not released");
  chk_line_a: assert property (onboard_int[0] |=> apic_hi_irq_q[0])
    else $error("APIC 16 missing line A");
  chk_port0_inta: assert property (ext_port_int[0].intx[0] |=> apic_hi_irq_q[0])
    else $error("port 0 INTA not on APIC 16");
  chk_port4_swz: assert property (ext_port_int[4].intx[0] |=> apic_hi_irq_q[1])
    else $error("port 4 INTA not on APIC 17");
  chk_port6_swz: assert property (ext_port_int[6].intx[1] |=> apic_hi_irq_q[0])
    else $error("port 6 INTB not on APIC 16");
  chk_line_d: assert property (ext_port_int[3].intx[0] |=> apic_hi_irq_q[3])
    else $error("APIC 19 missing line D");

  // ----------------------------------------
  // Window edges, probes at some boundaries only; 4Eh, 2E8h, 2F8h, 3E8h windows unprobed
  // ----------------------------------------
  // Off-by-one on a bound silently moves a port to the wrong bus
  chk_io_no_req: assert property (!io_req.valid |=> io_tgt_q == LPR_TGT_NONE)
    else $error("idle cycle forwarded");
  chk_io_below_win: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h002d) |=> io_tgt_q == LPR_TGT_PCI)
    else $error("port 2Dh sent to LPC");
  chk_io_win_2e: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h002e) |=> io_tgt_q == LPR_TGT_LPC)
    else $error("port 2Eh not sent to LPC");
  chk_io_gap_30: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h0030) |=> io_tgt_q == LPR_TGT_PCI)
    else $error("port 30h sent to LPC");
  chk_io_port60: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h0060) |=> io_tgt_q == LPR_TGT_LPC)
    else $error("port 60h not sent to LPC");
  chk_io_port65: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h0065) |=> io_tgt_q == LPR_TGT_PCI)
    else $error("port 65h sent to LPC");
  chk_io_lpt_top: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h037f) |=> io_tgt_q == LPR_TGT_LPC)
    else $error("port 37Fh not sent to LPC");
  chk_io_com_base: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h03f8) |=> io_tgt_q == LPR_TGT_LPC)
    else $error("port 3F8h not sent to LPC");
  chk_io_778_base: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h0778) |=> io_tgt_q == LPR_TGT_LPC)
    else $error("port 778h not sent to LPC");
  chk_io_77f_top: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h077f) |=> io_tgt_q == LPR_TGT_LPC)
    else $error("port 77Fh not sent to LPC");
  chk_io_below_a00: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h09ff) |=> io_tgt_q == LPR_TGT_PCI)
    else $error("port 9FFh sent to LPC");
  chk_io_win_a00: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h0a00) |=> io_tgt_q == LPR_TGT_LPC)
    else $error("port A00h not sent to LPC");
  chk_io_win_bff: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'h0bff) |=> io_tgt_q == LPR_TGT_LPC)
    else $error("port BFFh not sent to LPC");
  chk_io_pci_top: assert property (io_req.valid && !io_claimed && (io_req.addr == 16'hfff0) |=> io_tgt_q == LPR_TGT_PCI)
    else $error("top of I/O not subtractive");

  // ----------------------------------------
  // Legacy and APIC line checks
  // ----------------------------------------
  chk_free_slots: assert property (1'b1 |=> (legacy_irq_q & ~(LPR_IRQ_INTERNAL | LPR_IRQ_IDE)) == ($past(serirq_slots) & ~(LPR_IRQ_INTERNAL | LPR_IRQ_IDE)))
    else $error("free slot not on its line");
  chk_timer_line: assert property (serirq_slots[0] && !internal_irq[0] |=> !legacy_irq_q[0])
    else $error("line 0 taken by serial slot");
  chk_sysctl_line: assert property (internal_irq[9] |=> legacy_irq_q[9])
    else $error("line 9 lost internal source");
  chk_line_b: assert property (onboard_int[1] |=> apic_hi_irq_q[1])
    else $error("APIC 17 missing line B");
  chk_line_c: assert property (onboard_int[2] |=> apic_hi_irq_q[2])
    else $error("APIC 18 missing line C");
  chk_line_d_onb: assert property (onboard_int[3] |=> apic_hi_irq_q[3])
    else $error("APIC 19 missing onboard line D");
  chk_port1_inta: assert property (ext_port_int[1].intx[0] |=> apic_hi_irq_q[1])
    else $error("port 1 INTA not on APIC 17");
  chk_port2_inta: assert property (ext_port_int[2].intx[0] |=> apic_hi_irq_q[2])
    else $error("port 2 INTA not on APIC 18");
  chk_port5_inta: assert property (ext_port_int[5].intx[0] |=> apic_hi_irq_q[2])
    else $error("port 5 INTA not on APIC 18");
  chk_port4_intd: assert property (ext_port_int[4].intx[3] |=> apic_hi_irq_q[0])
    else $error("port 4 INTD not on APIC 16");
  chk_port3_intb: assert property (ext_port_int[3].intx[1] |=> apic_hi_irq_q[0])
    else $error("port 3 INTB not on APIC 16");
  chk_port5_intc: assert property (ext_port_int[5].intx[2] |=> apic_hi_irq_q[0])
    else $error("port 5 INTC not on APIC 16");
  chk_port2_intb: assert property (ext_port_int[2].intx[1] |=> apic_hi_irq_q[3])
    else $error("port 2 INTB not on APIC 19");
  // Lines E to H have no source inside the block; passed straight through
  chk_line_efgh: assert property (1'b1 |=> apic_hi_irq_q[7:4] == $past(pci_int_line_efgh))
    else $error("APIC 20..23 not passed through");

  // ----------------------------------------
  // Reset checks
  // ----------------------------------------
  // Own clock and no disable, so a mid-run reset is watched too
  chk_rst_tgt: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> io_tgt_q == LPR_TGT_NONE)
    else $error("target not idle after reset");
  chk_rst_legacy: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> legacy_irq_q == LPR_RST_IRQ)
    else $error("legacy lines not cleared by reset");
  chk_rst_apic: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> apic_hi_irq_q == LPR_RST_APIC)
    else $error("APIC lines not cleared by reset");

  cov_lpc_cycle: cover property (io_tgt_q == LPR_TGT_LPC);
  cov_pci_cycle: cover property (io_tgt_q == LPR_TGT_PCI);
  cov_ide_swap: cover property (legacy_ide_mode ##1 !legacy_ide_mode);
  cov_all_pci: cover property (apic_hi_irq_q[3:0] == 4'hf);
  cov_claimed: cover property (io_req.valid && io_claimed);

endmodule
`default_nettype wire

// ==== hdl/lpr_pkg.sv ====
// Package: constants and carriers for LPC I/O steering and IRQ routing.
// Assumes: single 100 MHz clock, synchronous active-high reset.
package lpr_pkg;

  // ----------------------------------------
  // I/O windows forwarded to LPC
  // ----------------------------------------
  localparam int          LPR_NUM_WIN = 13;
  localparam logic [15:0] LPR_WIN_LO [LPR_NUM_WIN] = '{
    16'h002e, 16'h004e, 16'h0060, 16'h0064, 16'h02e8, 16'h02f8, 16'h0378,
    16'h03e8, 16'h03f8, 16'h0778, 16'h0a00, 16'h0000, 16'h0000};
  localparam logic [15:0] LPR_WIN_HI [LPR_NUM_WIN] = '{
    16'h002f, 16'h004f, 16'h0060, 16'h0064, 16'h02ef, 16'h02ff, 16'h037f,
    16'h03ef, 16'h03ff, 16'h077f, 16'h0bff, 16'h0000, 16'h0000};
  localparam int          LPR_USED_WIN = 11;
  localparam logic [15:0] LPR_PCI_IO_TOP = 16'hfff0;

  // ----------------------------------------
  // Interrupt lines
  // ----------------------------------------
  localparam logic [15:0] LPR_IRQ_INTERNAL = 16'h2307; // 0,1,2,8,9,13
  localparam logic [15:0] LPR_IRQ_IDE      = 16'hc000; // 14,15
  localparam int          LPR_APIC_PCI_BASE = 16;
  localparam int          LPR_NUM_EXT_PORT  = 7;
  localparam logic [1:0]  LPR_PORT_SWZ [LPR_NUM_EXT_PORT] = '{
    2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
  localparam logic [15:0] LPR_RST_IRQ = 16'h0000;
  localparam logic [7:0]  LPR_RST_APIC = 8'h00;

  typedef enum logic [1:0] {LPR_TGT_NONE, LPR_TGT_LPC, LPR_TGT_PCI} lpr_tgt_e;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } lpr_io_req_s;

  typedef struct packed {
    logic [3:0] intx; // pin A..D of one port
  } lpr_port_int_s;

endpackage

// ==== bench/lpr_sio_model.sv ====
// Carrier LPC peripheral model: drives decoded serial IRQ slot levels.
// Assumes: bench asks for lines via want; one clock of slot latency.
`timescale 1ns/1ps
`default_nettype none
module lpr_sio_model (
  input  wire logic        clk,
  input  wire logic [15:0] want,
  output logic [15:0]      serirq_slots
);
  // Slot n carries line n; internal lines may be hit too, design must drop them
  always_ff @(posedge clk) begin
    serirq_slots <= want;
  end
endmodule
`default_nettype wire

// ==== bench/lpr_route_test.sv ====
// Bench: random I/O cycles and interrupt levels against lpr_route.
// Assumes: outputs registered one edge after the inputs they follow.
`timescale 1ns/1ps
`default_nettype none
module lpr_route_test;
  import lpr_pkg::*;
  logic clk, rst, io_claimed, ide_mode, live;
  lpr_io_req_s io_req;
  logic [15:0] want, slots, intl, e_leg;
  logic [1:0] ide;
  logic [3:0] onb, efgh;
  lpr_port_int_s ext [LPR_NUM_EXT_PORT];
  lpr_tgt_e tgt, e_tgt;
  logic [15:0] leg;
  logic [7:0] apic, e_apic;
  int miscompares, total_checks, cyc, seed;
  logic [31:0] a, b;
  logic [15:0] corner [16] = '{16'h0060, 16'h0064, 16'h0065, 16'h0a00, 16'h0bff,
                               16'h0c00, 16'hfff0, 16'h002e, 16'h0030, 16'h077f,
                               16'h0061, 16'h002d, 16'h09ff, 16'h03f8, 16'h037f, 16'h0778};
  lpr_sio_model u_sio (.clk(clk), .want(want), .serirq_slots(slots));
  lpr_route u_dut (.clk(clk), .rst(rst), .io_req(io_req), .io_claimed(io_claimed),
    .legacy_ide_mode(ide_mode), .serirq_slots(slots), .ide_irq(ide), .internal_irq(intl),
    .onboard_int(onb), .ext_port_int(ext), .pci_int_line_efgh(efgh),
    .io_tgt_q(tgt), .legacy_irq_q(leg), .apic_hi_irq_q(apic));
  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic lpr_tgt_e f_tgt();
    f_tgt = LPR_TGT_NONE;
    if (io_req.valid && !io_claimed) begin
      f_tgt = LPR_TGT_PCI;
      for (int w = 0; w < LPR_USED_WIN; w++) begin
        if (io_req.addr >= LPR_WIN_LO[w] && io_req.addr <= LPR_WIN_HI[w]) f_tgt = LPR_TGT_LPC;
      end
    end
  endfunction
  function automatic logic [7:0] f_apic();
    logic [3:0] l;
    l = onb;
    for (int n = 0; n < LPR_NUM_EXT_PORT; n++) begin
      for (int i = 0; i < 4; i++) begin
        if (ext[n].intx[i]) l[(LPR_PORT_SWZ[n] + i) % 4] = 1'b1;
      end
    end
    return {efgh, l};
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, checking, stimulus
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (live) begin
      chk({14'h0, tgt}, {14'h0, e_tgt});
      chk(leg, e_leg);
      chk({8'h0, apic}, {8'h0, e_apic});
    end
    live <= 1'b1;
    e_tgt <= rst ? LPR_TGT_NONE : f_tgt();
    e_leg <= rst ? 16'h0 : (intl & LPR_IRQ_INTERNAL) | (slots & ~(LPR_IRQ_INTERNAL | LPR_IRQ_IDE))
                          | (ide_mode ? {ide, 14'h0} : slots & LPR_IRQ_IDE);
    e_apic <= rst ? 8'h0 : f_apic();
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    seed = 11017;
    live = 0;
    rst = 1;
    io_req = '0;
    {io_claimed, ide_mode, want, ide, intl, onb, efgh} = '0;
    ext = '{default: '0};
    repeat (12) @(posedge clk);
    for (int k = 0; k < 2000; k++) begin
      a = $random(seed);
      b = $random(seed);
      rst <= (k == 900); // Mid-run reset must clear outputs too
      io_req <= '{valid: k < 16 || a[20], addr: k < 16 ? corner[k] : a[15:0]};
      io_claimed <= k >= 16 && a[22] && a[23] && (a[15:0] < LPR_PCI_IO_TOP);
      ide_mode <= k[7];
      want <= a[15:0] & b[15:0];
      ide <= b[17:16];
      intl <= b[31:16];
      onb <= b[11:8] & b[15:12];
      efgh <= a[27:24];
      for (int n = 0; n < LPR_NUM_EXT_PORT; n++) ext[n] <= (b[2:0] == n) ? b[7:4] : 4'h0;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
